// ---- hw/lqdt_pkg.sv ----
// constants and carrier types for the link queue data transfer block
package lqdt_pkg;
    localparam int UNIT_W = 32;
    localparam int LEN_W = 3;
    localparam int UID_W = 8;
    localparam int CNT_W = 3;
    localparam int SRC_DEPTH = 4;
    localparam int SNK_DEPTH = 4;
    localparam int DROP_W = 16;
    localparam logic [LEN_W-1:0] MAX_LEN_RST = 3'h4;
    localparam logic [CNT_W-1:0] SRC_K_RST = 3'h4;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_DROP = 8'h08;
    localparam logic [7:0] REG_RXBUF = 8'h0C;
    // field positions
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_SNK_LSB = 2;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_LEN_LSB = 8;
    localparam int CTRL_K_LSB = 12;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_TX_LSB = 4;
    localparam int STAT_RX_LSB = 8;
    localparam int RXBUF_LEN_LSB = 0;

    typedef enum logic [1:0] {
        BIND_NONE = 2'h0, BIND_QUEUE = 2'h1, BIND_BUFFER = 2'h2
    } lqdt_bind_t;
    typedef enum logic [1:0] {
        MODE_UNORDERED = 2'h0, MODE_ORDERED = 2'h1, MODE_CLASSICAL = 2'h2, MODE_DISORDERED = 2'h3
    } lqdt_mode_t;
    typedef enum logic [2:0] {
        ST_SUCCESS = 3'h0, ST_QFULL = 3'h1, ST_LENGTH = 3'h2, ST_STATE = 3'h3,
        ST_RESET = 3'h4, ST_TIMEOUT = 3'h5, ST_UNSPEC = 3'h6
    } lqdt_status_t;
    typedef enum logic [1:0] {
        ORIG_USER = 2'h0, ORIG_PROV_REMOTE = 2'h1, ORIG_PROV_LOCAL = 2'h2, ORIG_UNKNOWN = 2'h3
    } lqdt_orig_t;
    typedef enum logic [1:0] {S_IDLE, S_CONNECTING, S_READY, S_DRAIN} lqdt_state_t;

    typedef struct packed {
        logic [LEN_W-1:0] len;
        logic [UNIT_W-1:0] data;
    } lqdt_sdu_t;
    typedef struct packed {
        logic [UID_W-1:0] uid;
        lqdt_sdu_t sdu;
    } lqdt_send_t;
    typedef struct packed {
        logic [UID_W-1:0] uid;
        lqdt_status_t status;
    } lqdt_cnf_t;
    typedef struct packed {
        logic [UID_W-1:0] uid;
        logic has_data;
        lqdt_sdu_t sdu;
    } lqdt_ind_t;
    typedef struct packed {
        logic [UID_W-1:0] uid;
        lqdt_orig_t orig;
    } lqdt_rel_t;
    typedef struct packed {
        lqdt_bind_t src;
        lqdt_bind_t snk;
        lqdt_mode_t mode;
        logic [LEN_W-1:0] max_len;
        logic [CNT_W-1:0] src_k;
    } lqdt_cfg_t;
    typedef struct packed {
        lqdt_state_t state;
        logic [CNT_W-1:0] tx_cnt;
        logic [CNT_W-1:0] rx_cnt;
        logic [DROP_W-1:0] drops;
        lqdt_sdu_t rxbuf;
    } lqdt_stat_t;
endpackage

// ---- hw/lqdt_fifo.sv ----
// synchronous fifo holding whole units for the send and receive queues
`timescale 1ns/10ps
module lqdt_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4,
    parameter int CW = 3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic push,
    input wire logic [W-1:0] wdata,
    input wire logic pop,
    output logic [W-1:0] rdata,
    output logic empty,
    output logic [CW-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW-1:0] next_wr_ptr;
    logic [CW-1:0] next_count;
    logic do_push;
    logic do_pop;

    // depth must be a power of two so the pointers wrap by themselves
    always_comb begin
        do_push = push && (count < CW'(DEPTH)) && !flush;
        do_pop = pop && !empty && !flush;
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_count = count;
        if (flush) begin
            next_rd_ptr = '0;
            next_wr_ptr = '0;
            next_count = '0;
        end else begin
            if (do_push) begin
                next_wr_ptr = wr_ptr + 1'b1;
            end
            if (do_pop) begin
                next_rd_ptr = rd_ptr + 1'b1;
            end
            next_count = count + CW'(do_push) - CW'(do_pop);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= wdata;
        end
    end

    assign rdata = mem[rd_ptr];
    assign empty = (count == '0);
endmodule

// ---- hw/lqdt_apb.sv ----
// apb slave holding the configuration register and reading back status
`timescale 1ns/10ps
module lqdt_apb (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output lqdt_pkg::lqdt_cfg_t cfg,
    input wire lqdt_pkg::lqdt_stat_t stat
);
    import lqdt_pkg::*;
    lqdt_cfg_t next_cfg;
    logic [31:0] next_prdata;
    logic [31:0] rd_word;
    logic mapped;
    logic read_only;

    always_comb begin
        rd_word = 32'h0;
        mapped = 1'b1;
        read_only = 1'b1;
        case (paddr)
            REG_CTRL: begin
                read_only = 1'b0;
                rd_word[CTRL_SRC_LSB +: 2] = cfg.src;
                rd_word[CTRL_SNK_LSB +: 2] = cfg.snk;
                rd_word[CTRL_MODE_LSB +: 2] = cfg.mode;
                rd_word[CTRL_LEN_LSB +: LEN_W] = cfg.max_len;
                rd_word[CTRL_K_LSB +: CNT_W] = cfg.src_k;
            end
            REG_STAT: begin
                rd_word[STAT_STATE_LSB +: 2] = stat.state;
                rd_word[STAT_TX_LSB +: CNT_W] = stat.tx_cnt;
                rd_word[STAT_RX_LSB +: CNT_W] = stat.rx_cnt;
            end
            REG_DROP: rd_word[DROP_W-1:0] = stat.drops;
            REG_RXBUF: rd_word[RXBUF_LEN_LSB +: UNIT_W] = stat.rxbuf.data;
            default: mapped = 1'b0;
        endcase
        next_cfg = cfg;
        next_prdata = prdata;
        // read data is captured in the setup phase so it comes from a flop
        if (psel && !penable) begin
            next_prdata = rd_word;
        end
        if (psel && penable && pwrite && paddr == REG_CTRL) begin
            next_cfg.src = lqdt_bind_t'(pwdata[CTRL_SRC_LSB +: 2]);
            next_cfg.snk = lqdt_bind_t'(pwdata[CTRL_SNK_LSB +: 2]);
            next_cfg.mode = lqdt_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
            next_cfg.max_len = pwdata[CTRL_LEN_LSB +: LEN_W];
            next_cfg.src_k = pwdata[CTRL_K_LSB +: CNT_W];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg <= '{BIND_NONE, BIND_NONE, MODE_UNORDERED, MAX_LEN_RST, SRC_K_RST};
            prdata <= 32'h0;
        end else begin
            cfg <= next_cfg;
            prdata <= next_prdata;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && (!mapped || (pwrite && read_only));
endmodule

// ---- hw/lqdt_top.sv ----
// link queue data transfer: release handling, send queue and receive queue
// Behaviour
// - release caused by a user refusal carries the user originator
// - provider unable to set up signals release with provider originator
// - units move both ways at once with their boundaries kept
// - send with buffer source is invalid; connection ends with release
// - bound source queue of depth K refuses a send when holding K
// - queued units go out first chance, strictly in queue order
// - no buffer write on queue source; depth bounds unconfirmed sends
// - unbound source uses an implicit queue and fails when full
// - send into a full queue is refused at once with failure status
// - bound sink queue takes the unit; indication carries no payload
// - unbound sink buffers the unit then delivers it in the indication
// - buffer bound as sink: never a data indication
// - unordered or ordered: unqueueable unit dropped, no indication
// - classical or disordered: unqueueable unit held until delivered or reset
// - send status is one of seven values
// - sends accepted only when ready for data transfer, else state failure; during drain the send is held off (send_ready low) instead
// - data indication reports the identifier from connection setup
// - outstanding send confirms come before the release indication
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
module lqdt_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conn_req,
    input wire logic [lqdt_pkg::UID_W-1:0] conn_uid,
    input wire logic peer_conn_ok,
    input wire logic peer_conn_fail,
    input wire logic peer_rel,
    input wire logic rel_req,
    output logic conn_up,
    output logic rel_ind,
    output lqdt_pkg::lqdt_rel_t rel_info,
    input wire logic send_valid,
    input wire lqdt_pkg::lqdt_send_t send,
    output logic send_ready,
    output logic cnf_valid,
    output lqdt_pkg::lqdt_cnf_t cnf,
    output logic ind_valid,
    output lqdt_pkg::lqdt_ind_t ind,
    input wire logic ind_ready,
    input wire logic qread_req,
    output logic qread_valid,
    output lqdt_pkg::lqdt_ind_t qread_data,
    output logic tx_valid,
    output lqdt_pkg::lqdt_sdu_t tx_sdu,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire lqdt_pkg::lqdt_sdu_t rx_sdu,
    output logic rx_ready,
    input wire logic rx_abort
);
    import lqdt_pkg::*;

    lqdt_cfg_t cfg;
    lqdt_stat_t stat;
    lqdt_state_t state, next_state;
    logic [UID_W-1:0] uid, next_uid;
    logic drain_ind, next_drain_ind;
    lqdt_orig_t drain_orig, next_drain_orig;
    logic next_conn_up, next_rel_ind, next_cnf_valid, next_qind, qind;
    lqdt_rel_t next_rel_info;
    lqdt_cnf_t next_cnf;
    logic next_qread_valid;
    lqdt_ind_t next_qread_data;
    logic [DROP_W-1:0] drops, next_drops;
    lqdt_sdu_t rxbuf, next_rxbuf;
    logic tx_push, tx_pop, tx_flush, tx_empty, tx_full, tx_done;
    logic rx_push, rx_pop, rx_flush, rx_empty, rx_full, rx_take;
    logic [CNT_W-1:0] tx_cnt, rx_cnt;
    logic [$bits(lqdt_send_t)-1:0] tx_rdata;
    logic [$bits(lqdt_sdu_t)-1:0] rx_rdata;
    lqdt_send_t tx_head;
    lqdt_sdu_t rx_head;
    logic send_take, len_bad, lossy, implicit_rx;

    // ****************************************************************
    // register slave and queues
    // ****************************************************************
    lqdt_apb u_apb (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg(cfg), .stat(stat)
    );

    lqdt_fifo #(.W($bits(lqdt_send_t)), .DEPTH(SRC_DEPTH), .CW(CNT_W)) u_txq (
        .clk(clk), .srst(srst), .flush(tx_flush), .push(tx_push), .wdata(send),
        .pop(tx_pop), .rdata(tx_rdata), .empty(tx_empty), .count(tx_cnt)
    );

    lqdt_fifo #(.W($bits(lqdt_sdu_t)), .DEPTH(SNK_DEPTH), .CW(CNT_W)) u_rxq (
        .clk(clk), .srst(srst), .flush(rx_flush), .push(rx_push), .wdata(rx_sdu),
        .pop(rx_pop), .rdata(rx_rdata), .empty(rx_empty), .count(rx_cnt)
    );

    assign tx_head = tx_rdata;
    assign rx_head = rx_rdata;
    assign stat = '{state, tx_cnt, rx_cnt, drops, rxbuf};

    // ****************************************************************
    // send side
    // ****************************************************************
    // a bound queue is capped at K, the implicit one at the full depth
    assign tx_full = (cfg.src == BIND_QUEUE) ? (tx_cnt >= cfg.src_k)
                                             : (tx_cnt == CNT_W'(SRC_DEPTH));
    assign tx_valid = (state == S_READY) && !tx_empty;
    assign tx_sdu = tx_head.sdu;
    assign tx_done = tx_valid && tx_ready;
    // a send is held off while a transmit confirm takes the confirm port
    assign send_ready = (state != S_DRAIN) && !tx_done;
    assign send_take = send_valid && send_ready;
    assign len_bad = (send.sdu.len == '0) || (send.sdu.len > cfg.max_len);
    assign tx_push = send_take && (state == S_READY) && (cfg.src != BIND_BUFFER)
                     && !len_bad && !tx_full;
    assign tx_pop = tx_done || (state == S_DRAIN && !tx_empty);
    assign tx_flush = (state == S_DRAIN) && tx_empty;

    // ****************************************************************
    // receive side
    // ****************************************************************
    assign rx_full = (rx_cnt == CNT_W'(SNK_DEPTH));
    assign lossy = (cfg.mode == MODE_UNORDERED) || (cfg.mode == MODE_ORDERED);
    assign implicit_rx = (cfg.snk == BIND_NONE);
    // holding off the link keeps the unit at the sender until room appears
    assign rx_ready = (state != S_READY) || (cfg.snk == BIND_BUFFER) || !rx_full
                      || lossy;
    assign rx_take = rx_valid && rx_ready && (state == S_READY);
    assign rx_push = rx_take && (cfg.snk != BIND_BUFFER) && !rx_full;
    assign rx_flush = rx_abort || tx_flush;
    assign rx_pop = implicit_rx ? (ind_valid && !qind && ind_ready)
                                : (qread_req && cfg.snk == BIND_QUEUE);
    assign ind_valid = qind || (implicit_rx && !rx_empty && state == S_READY);
    always_comb begin
        ind.uid = uid;
        ind.has_data = !qind;
        ind.sdu = qind ? '0 : rx_head;
    end

    // ****************************************************************
    // connection state and primitive outputs
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_uid = uid;
        next_drain_ind = drain_ind;
        next_drain_orig = drain_orig;
        next_conn_up = 1'b0;
        next_rel_ind = 1'b0;
        next_rel_info = rel_info;
        next_cnf_valid = 1'b0;
        next_cnf = cnf;
        next_qind = rx_push && cfg.snk == BIND_QUEUE;
        next_drops = drops;
        next_rxbuf = rxbuf;
        next_qread_valid = qread_req;
        next_qread_data = qread_data;
        if (qread_req) begin
            next_qread_data = '{uid, !rx_empty, rx_empty ? '0 : rx_head};
        end
        if (rx_take && cfg.snk == BIND_BUFFER) begin
            next_rxbuf = rx_sdu;
        end
        if (rx_take && cfg.snk != BIND_BUFFER && rx_full) begin
            next_drops = drops + 1'b1;
        end
        if (send_take) begin
            next_cnf_valid = !tx_push;
            next_cnf.uid = send.uid;
            if (state != S_READY) begin
                next_cnf.status = ST_STATE;
            end else if (cfg.src == BIND_BUFFER) begin
                next_cnf.status = ST_UNSPEC;
            end else if (len_bad) begin
                next_cnf.status = ST_LENGTH;
            end else begin
                next_cnf.status = ST_QFULL;
            end
        end
        if (tx_done) begin
            next_cnf_valid = 1'b1;
            next_cnf = '{tx_head.uid, ST_SUCCESS};
        end
        case (state)
            S_IDLE: begin
                if (conn_req) begin
                    next_uid = conn_uid;
                    next_state = S_CONNECTING;
                end
            end
            S_CONNECTING: begin
                if (rel_req) begin
                    next_state = S_IDLE;
                end else if (peer_conn_fail) begin
                    next_rel_ind = 1'b1;
                    next_rel_info = '{uid, ORIG_PROV_LOCAL};
                    next_state = S_IDLE;
                end else if (peer_rel) begin
                    next_rel_ind = 1'b1;
                    next_rel_info = '{uid, ORIG_USER};
                    next_state = S_IDLE;
                end else if (peer_conn_ok) begin
                    next_conn_up = 1'b1;
                    next_state = S_READY;
                end
            end
            S_READY: begin
                if (rel_req) begin
                    next_drain_ind = 1'b0;
                    next_state = S_DRAIN;
                end else if (send_take && cfg.src == BIND_BUFFER) begin
                    next_drain_ind = 1'b1;
                    next_drain_orig = ORIG_PROV_LOCAL;
                    next_state = S_DRAIN;
                end else if (peer_rel) begin
                    next_drain_ind = 1'b1;
                    next_drain_orig = ORIG_USER;
                    next_state = S_DRAIN;
                end
            end
            S_DRAIN: begin
                // every unsent unit is confirmed before the release shows
                if (!tx_empty) begin
                    next_cnf_valid = 1'b1;
                    next_cnf = '{tx_head.uid, ST_RESET};
                end else begin
                    next_rel_ind = drain_ind;
                    next_rel_info = '{uid, drain_orig};
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= S_IDLE;
            uid <= '0;
            drain_ind <= 1'b0;
            drain_orig <= ORIG_UNKNOWN;
            conn_up <= 1'b0;
            rel_ind <= 1'b0;
            rel_info <= '{'0, ORIG_UNKNOWN};
            cnf_valid <= 1'b0;
            cnf <= '{'0, ST_SUCCESS};
            qind <= 1'b0;
            drops <= '0;
            rxbuf <= '0;
            qread_valid <= 1'b0;
            qread_data <= '0;
        end else begin
            state <= next_state;
            uid <= next_uid;
            drain_ind <= next_drain_ind;
            drain_orig <= next_drain_orig;
            conn_up <= next_conn_up;
            rel_ind <= next_rel_ind;
            rel_info <= next_rel_info;
            cnf_valid <= next_cnf_valid;
            cnf <= next_cnf;
            qind <= next_qind;
            drops <= next_drops;
            rxbuf <= next_rxbuf;
            qread_valid <= next_qread_valid;
            qread_data <= next_qread_data;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_state_fail: assert property (send_take && state != S_READY |=>
        cnf_valid && cnf.status == ST_STATE) else $error("send outside ready not refused");
    a_queue_full: assert property (send_take && state == S_READY && cfg.src != BIND_BUFFER
        && !len_bad && tx_full |=> cnf_valid && cnf.status == ST_QFULL
        && $stable(tx_cnt)) else $error("send into full queue not refused");
    a_buf_source: assert property (send_take && state == S_READY && cfg.src == BIND_BUFFER
        && !rel_req |=> state == S_DRAIN ##[1:8] rel_ind
        && rel_info.orig == ORIG_PROV_LOCAL) else $error("buffer source send kept link");
    a_setup_fail: assert property (state == S_CONNECTING && peer_conn_fail && !rel_req
        |=> rel_ind && rel_info.orig == ORIG_PROV_LOCAL && state == S_IDLE)
        else $error("failed setup not released by provider");
    a_reject_orig: assert property (state == S_CONNECTING && peer_rel && !rel_req
        && !peer_conn_fail |=> rel_ind && rel_info.orig == ORIG_USER)
        else $error("user refusal has wrong originator");
    a_tx_hold: assert property (tx_valid && !tx_ready && state == S_READY
        && !rel_req && !peer_rel |=> tx_valid && $stable(tx_sdu))
        else $error("queued unit changed before sent");
    a_sink_buffer: assert property (cfg.snk == BIND_BUFFER && $past(cfg.snk) == BIND_BUFFER
        |-> !ind_valid) else $error("indication with buffer sink");
    a_drop_count: assert property (rx_take && cfg.snk != BIND_BUFFER && rx_full && lossy
        |=> drops == $past(drops) + 1'b1 && !qind) else $error("lost unit not counted");
    a_retain: assert property (state == S_READY && cfg.snk != BIND_BUFFER && rx_full
        && !lossy |-> !rx_ready) else $error("unit accepted into full queue");
    a_cnf_first: assert property (state == S_DRAIN && !tx_empty |=>
        cnf_valid && cnf.status == ST_RESET && !rel_ind)
        else $error("release before outstanding confirms");
    a_queue_ind: assert property (rx_push && cfg.snk == BIND_QUEUE |=>
        ind_valid && !ind.has_data && ind.uid == uid) else $error("queue sink indication wrong");

    c_connect: cover property (state == S_CONNECTING ##1 conn_up);
    c_sent: cover property (tx_done ##1 cnf_valid && cnf.status == ST_SUCCESS);
    c_full: cover property (cnf_valid && cnf.status == ST_QFULL);
    c_drain: cover property (state == S_DRAIN && !tx_empty ##[1:8] rel_ind);
endmodule

// ---- sim/lqdt_peer.sv ----
// peer link entity model taking transmitted units with random stalls
`timescale 1ns/10ps
module lqdt_peer (
    input wire logic clk,
    input wire logic stall,
    input wire logic tx_valid,
    input wire lqdt_pkg::lqdt_sdu_t tx_sdu,
    output logic tx_ready,
    output logic got,
    output lqdt_pkg::lqdt_sdu_t got_sdu
);
    import lqdt_pkg::*;
    int seed = 56;
    initial begin
        tx_ready = 1'b0;
        got = 1'b0;
    end
    // a slow peer: ready only on about half the cycles
    always @(posedge clk) begin
        got <= tx_valid && tx_ready;
        got_sdu <= tx_sdu;
        tx_ready <= !stall && (($random(seed) & 1) == 0);
    end
endmodule

// ---- sim/lqdt_top_bench.sv ----
// self-checking bench for the link queue data transfer block
`timescale 1ns/10ps
module lqdt_top_bench;
    import lqdt_pkg::*;
    logic clk, srst, psel, penable, pwrite, conn_req, peer_conn_ok, peer_conn_fail, peer_rel;
    logic rel_req, send_valid, ind_ready, qread_req, rx_valid, rx_abort, stall, er;
    logic pready, pslverr, conn_up, rel_ind, send_ready, cnf_valid, ind_valid, qread_valid;
    logic tx_valid, tx_ready, rx_ready, got;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [UID_W-1:0] conn_uid;
    lqdt_rel_t rel_info;
    lqdt_send_t send;
    lqdt_cnf_t cnf;
    lqdt_ind_t ind, qread_data;
    lqdt_sdu_t tx_sdu, rx_sdu, got_sdu;
    logic [5:0] strobe;
    int err_total = 0, checks = 0, seed = 56, cyc = 0;
    lqdt_cnf_t exp_cnf[$], exp_q[$];
    lqdt_sdu_t exp_tx[$], last_rx;
    lqdt_ind_t exp_rx[$];
    lqdt_top DUT (.*);
    // one-cycle user and provider strobes all come from one driver
    assign {qread_req, rel_req, peer_rel, peer_conn_fail, peer_conn_ok, conn_req} = strobe;
    lqdt_peer peer (.clk(clk), .stall(stall), .tx_valid(tx_valid), .tx_sdu(tx_sdu),
        .tx_ready(tx_ready), .got(got), .got_sdu(got_sdu));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] a, input logic [63:0] b);
        checks++;
        if (a !== b) begin
            err_total++;
            $display("[ERR] t=%0t got %h exp %h", $time, a, b);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    // idle edge after each pulse so a following pulse never reassigns strobe in one step
    task automatic pulse(input int k);
        strobe <= 6'h01 << k;
        @(posedge clk);
        strobe <= 6'h00;
        @(posedge clk);
    endtask
    task automatic waitfor(input int k);
        int n = 0;
        while ((k != 0 ? rel_ind : conn_up) !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk(k != 0 ? rel_ind : conn_up, 1);
    endtask
    task automatic snd(input logic [2:0] len, input lqdt_status_t st);
        lqdt_send_t s;
        s = {UID_W'($random(seed)), len, 32'($random(seed))};
        send <= s;
        send_valid <= 1;
        do @(posedge clk); while (send_ready !== 1'b1);
        send_valid <= 0;
        if (st == ST_SUCCESS) exp_tx.push_back(s.sdu);
        // accepted units confirm later in queue order, refusals on the next cycle
        if (st == ST_SUCCESS || st == ST_RESET) exp_q.push_back({s.uid, st});
        else exp_cnf.push_back({s.uid, st});
        @(posedge clk);
    endtask
    task automatic connect(input int k);
        pulse(0);
        pulse(k);
    endtask
    task automatic recv(input logic hd);
        lqdt_sdu_t u;
        u = {3'h2, 32'($random(seed))};
        last_rx = u;
        rx_sdu <= u;
        rx_valid <= 1;
        do @(posedge clk); while (rx_ready !== 1'b1);
        rx_valid <= 0;
        exp_rx.push_back({8'h5A, hd, hd ? 35'(u) : 35'h0});
    endtask
    // ************ monitors ************
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            wrap_up();
        end
        // a confirm beside a peer take is a transmit confirm; pending refusals come first
        if (cnf_valid === 1'b1 && (got === 1'b1 || exp_cnf.size() == 0)) begin
            chk(cnf, exp_q.pop_front());
        end else if (cnf_valid === 1'b1) begin
            chk(cnf, exp_cnf.pop_front());
        end
        if (got === 1'b1) chk(got_sdu, exp_tx.pop_front());
        if (ind_valid === 1'b1) chk(ind, exp_rx.pop_front());
    end
    initial begin
        {psel, penable, pwrite, strobe} = 0;
        {send_valid, rx_valid, rx_abort, paddr, pwdata, send, rx_sdu} = 0;
        conn_uid = 8'h5A;
        ind_ready = 1;
        stall = 1;
        srst = 1;
        repeat (10) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        apb(0, REG_CTRL, 0);
        chk(rd, 32'h4400);
        apb(1, REG_CTRL, 32'h4401);
        apb(1, REG_STAT, 0);
        chk(er, 1);
        apb(0, 8'h10, 0);
        chk({er, rd}, 33'h100000000);
        snd(1, ST_STATE);
        connect(1);
        waitfor(0);
        for (int i = 1; i <= 4; i++) snd(3'(i), ST_SUCCESS);
        snd(2, ST_QFULL);
        snd(0, ST_LENGTH);
        snd(5, ST_LENGTH);
        stall <= 0;
        recv(1);
        repeat (40) @(posedge clk);
        stall <= 1;
        repeat (3) @(posedge clk);
        snd(4, ST_RESET);
        snd(1, ST_RESET);
        pulse(3);
        waitfor(1);
        chk(exp_q.size(), 0);
        chk(rel_info.orig, ORIG_USER);
        connect(3);
        waitfor(1);
        chk(rel_info.orig, ORIG_USER);
        connect(4);
        chk(rel_ind, 0);
        apb(0, REG_STAT, 0);
        chk(rd, 32'h0);
        connect(2);
        waitfor(1);
        chk(rel_info.orig, ORIG_PROV_LOCAL);
        apb(1, REG_CTRL, 32'h4402);
        connect(1);
        snd(1, ST_UNSPEC);
        waitfor(1);
        chk(rel_info.orig, ORIG_PROV_LOCAL);
        apb(1, REG_CTRL, 32'h4404);
        connect(1);
        recv(0);
        repeat (2) @(posedge clk);
        pulse(5);
        chk(qread_valid, 1);
        chk(qread_data, {8'h5A, 1'b1, last_rx});
        repeat (5) @(posedge clk);
        wrap_up();
    end
endmodule
